// ==== hw/bmd_defs.vh ====
// constants for the bit manipulation datapath
`ifndef BMD_DEFS_VH
`define BMD_DEFS_VH

// register word offsets on the software port
`define BMD_REG_CTRL    8'h00
`define BMD_REG_COUNT   8'h01
`define BMD_REG_SRC     8'h02
`define BMD_REG_DST     8'h03
`define BMD_REG_STATUS  8'h04
`define BMD_REG_MASK    8'h05

// control register fields
`define BMD_CTRL_OP_LSB 0
`define BMD_CTRL_OP_MSB 2
`define BMD_CTRL_W32    3
`define BMD_CTRL_PULSE  4
`define BMD_CTRL_SIN    5
`define BMD_CTRL_RESET  16'h0000

// operation codes
`define BMD_OP_PACK     3'h0
`define BMD_OP_UNPACK   3'h1
`define BMD_OP_SHL      3'h2
`define BMD_OP_SHR      3'h3
`define BMD_OP_ROL      3'h4
`define BMD_OP_ROR      3'h5
`define BMD_OP_GRAY     3'h6

// status and mask fields
`define BMD_ST_DONE     0
`define BMD_ST_CERR     1
`define BMD_ST_BUSY     2
`define BMD_ST_SOUT     3
`define BMD_EVT_W       2

// count limits
`define BMD_BYTE_MAX    16'h0100
`define BMD_BITS16      16'h0010
`define BMD_BITS32      16'h0020

`endif

// ==== hw/bmd_shifter.v ====
// shift, rotate and gray conversion of one 16 or 32 bit operand
`timescale 1ns/1ps
`include "bmd_defs.vh"

module bmd_shifter (
  input  wire [31:0] data_i,  // operand, upper half zero when 16-bit
  input  wire [5:0]  cnt_i,   // places, 1 to 16 or 1 to 32
  input  wire [2:0]  op_i,    // operation code
  input  wire        w32_i,   // 32-bit operand
  input  wire        sin_i,   // shift-in bit
  output reg  [31:0] res_o,   // result
  output reg         sout_o   // last bit moved out
);

  reg [31:0] wmask;
  reg [63:0] tmp;
  reg [5:0]  wbits;
  reg [5:0]  back;

  // all paths of the datapath in one combinational process
  always @* begin
    wmask = w32_i ? 32'hFFFFFFFF : 32'h0000FFFF;
    wbits = w32_i ? 6'h20 : 6'h10;
    back = wbits - cnt_i;
    tmp = 64'h0;
    res_o = data_i;
    sout_o = 1'b0;
    case (op_i)
      `BMD_OP_SHL: begin
        tmp = {32'h0, data_i} << cnt_i;
        res_o = (tmp[31:0] & wmask) |
                ({32{sin_i}} & wmask & ~(wmask << cnt_i));
        sout_o = w32_i ? tmp[32] : tmp[16];
      end
      `BMD_OP_SHR: begin
        tmp = {data_i, 32'h0} >> cnt_i;
        res_o = tmp[63:32] |
                ({32{sin_i}} & wmask & ~(wmask >> cnt_i));
        sout_o = tmp[31];
      end
      `BMD_OP_ROL: begin
        res_o = ((data_i << cnt_i) | (data_i >> back)) & wmask;
        sout_o = res_o[0];
      end
      `BMD_OP_ROR: begin
        res_o = ((data_i >> cnt_i) | (data_i << back)) & wmask;
        sout_o = w32_i ? res_o[31] : res_o[15];
      end
      `BMD_OP_GRAY: begin
        res_o = (data_i ^ (data_i >> 1)) & wmask;
      end
      default: begin
        res_o = data_i;
      end
    endcase
  end

endmodule

// ==== hw/bmd_irq.v ====
// sticky event status, mask and level interrupt
`timescale 1ns/1ps
`include "bmd_defs.vh"

module bmd_irq (
  input  wire                 mclk_i,     // clock
  input  wire                 reset_n_i,  // sync reset, active low
  input  wire [`BMD_EVT_W-1:0] set_i,     // event pulses
  input  wire                 clr_we_i,   // status write strobe
  input  wire [`BMD_EVT_W-1:0] clr_i,     // ones clear bits
  input  wire                 mask_we_i,  // mask write strobe
  input  wire [`BMD_EVT_W-1:0] mask_i,    // new mask
  output reg  [`BMD_EVT_W-1:0] status_o,  // sticky bits
  output reg  [`BMD_EVT_W-1:0] mask_o,    // enable per bit
  output reg                  irq_o       // level interrupt
);

  wire [`BMD_EVT_W-1:0] next_status;

  // a set in the clearing cycle survives
  assign next_status = (status_o & ~({`BMD_EVT_W{clr_we_i}} & clr_i)) |
                       set_i;

  // status, mask and registered interrupt
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      status_o <= {`BMD_EVT_W{1'b0}};
      mask_o <= {`BMD_EVT_W{1'b0}};
      irq_o <= 1'b0;
    end else begin
      status_o <= next_status;
      if (mask_we_i) begin
        mask_o <= mask_i;
      end
      irq_o <= |(next_status & (mask_we_i ? mask_i : mask_o));
    end
  end

endmodule

// ==== hw/bmd_top.v ====
// bit and byte manipulation datapath with register port
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "bmd_defs.vh"

module bmd_top (
  input  wire        mclk_i,          // 250 MHz clock
  input  wire        reset_n_i,       // sync reset, active low
  input  wire        en_i,            // operation enable
  input  wire [7:0]  reg_addr_i,      // register word address
  input  wire [15:0] reg_wdata_i,     // register write data
  input  wire        reg_we_i,        // register write strobe
  input  wire        reg_re_i,        // register read strobe
  output reg  [15:0] reg_rdata_o,     // read data, one cycle later
  output reg  [15:0] mem_addr_o,      // register file word address
  output reg  [15:0] mem_wdata_o,     // register file write data
  output reg         mem_we_o,        // register file write strobe
  output reg         mem_re_o,        // register file read strobe
  input  wire [15:0] mem_rdata_i,     // read word, cycle after strobe
  output reg         shift_out_bit_o, // last bit shifted out
  output reg         busy_o,          // operation in progress
  output wire        irq_o            // level interrupt
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_RD    = 3'h1;
  localparam [2:0] ST_RWAIT = 3'h2;
  localparam [2:0] ST_CALC  = 3'h3;
  localparam [2:0] ST_WR    = 3'h4;

  // software registers
  reg [15:0] ctrl;
  reg [15:0] count;
  reg [15:0] src_base;
  reg [15:0] dst_base;

  // sequencer state
  reg [2:0]  state;
  reg [2:0]  op;
  reg        w32;
  reg        sin;
  reg [8:0]  n;
  reg [8:0]  k;
  reg [15:0] src;
  reg [15:0] dst;
  reg [15:0] hold;
  reg [31:0] acc;
  reg [31:0] res;
  reg        en_q;
  reg        evt_done;
  reg        evt_cerr;

  wire [2:0]  ctrl_op;
  wire        ctrl_w32;
  wire        ctrl_pulse;
  wire        start;
  wire        cnt_ok;
  wire        last_k;
  wire        word_last;
  wire        is_shift;
  wire [31:0] sh_res;
  wire        sh_sout;
  wire [`BMD_EVT_W-1:0] status;
  wire [`BMD_EVT_W-1:0] mask;

  // word address base plus step
  function [15:0] step_addr;
    input [15:0] base;
    input [8:0]  off;
    begin
      step_addr = base + {7'h00, off};
    end
  endfunction

  // count is legal for the chosen operation
  function count_legal;
    input [2:0]  f_op;
    input        f_w32;
    input [15:0] f_cnt;
    begin
      if (f_op == `BMD_OP_PACK || f_op == `BMD_OP_UNPACK) begin
        count_legal = (f_cnt != 16'h0000) &&
                      (f_cnt <= `BMD_BYTE_MAX);
      end else if (f_op == `BMD_OP_GRAY) begin
        count_legal = 1'b1;
      end else begin
        count_legal = (f_cnt != 16'h0000) &&
                      (f_cnt <= (f_w32 ? `BMD_BITS32 : `BMD_BITS16));
      end
    end
  endfunction

  assign ctrl_op = ctrl[`BMD_CTRL_OP_MSB:`BMD_CTRL_OP_LSB];
  assign ctrl_w32 = ctrl[`BMD_CTRL_W32];
  assign ctrl_pulse = ctrl[`BMD_CTRL_PULSE];

  // level enable repeats, pulse variant fires on the rising edge
  assign start = ctrl_pulse ? (en_i & ~en_q) : en_i;
  assign cnt_ok = count_legal(ctrl_op, ctrl_w32, count);
  assign last_k = (k == n - 9'h001);
  assign word_last = (k == {8'h00, w32});
  assign is_shift = (op == `BMD_OP_SHL) || (op == `BMD_OP_SHR) ||
                    (op == `BMD_OP_ROL) || (op == `BMD_OP_ROR);

  bmd_shifter u_shifter (
    .data_i (acc),
    .cnt_i  (n[5:0]),
    .op_i   (op),
    .w32_i  (w32),
    .sin_i  (sin),
    .res_o  (sh_res),
    .sout_o (sh_sout)
  );

  bmd_irq u_irq (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .set_i     ({evt_cerr, evt_done}),
    .clr_we_i  (reg_we_i && reg_addr_i == `BMD_REG_STATUS),
    .clr_i     (reg_wdata_i[`BMD_EVT_W-1:0]),
    .mask_we_i (reg_we_i && reg_addr_i == `BMD_REG_MASK),
    .mask_i    (reg_wdata_i[`BMD_EVT_W-1:0]),
    .status_o  (status),
    .mask_o    (mask),
    .irq_o     (irq_o)
  );

  // software writes to the setup registers
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ctrl <= `BMD_CTRL_RESET;
      count <= 16'h0000;
      src_base <= 16'h0000;
      dst_base <= 16'h0000;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        `BMD_REG_CTRL: ctrl <= reg_wdata_i & 16'h003F;
        `BMD_REG_COUNT: count <= reg_wdata_i;
        `BMD_REG_SRC: src_base <= reg_wdata_i;
        `BMD_REG_DST: dst_base <= reg_wdata_i;
        default: ctrl <= ctrl;
      endcase
    end
  end

  // read data stands the cycle after the strobe, unmapped reads zero
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        `BMD_REG_CTRL: reg_rdata_o <= ctrl;
        `BMD_REG_COUNT: reg_rdata_o <= count;
        `BMD_REG_SRC: reg_rdata_o <= src_base;
        `BMD_REG_DST: reg_rdata_o <= dst_base;
        `BMD_REG_STATUS: reg_rdata_o <= {12'h000, shift_out_bit_o,
                                         busy_o, status};
        `BMD_REG_MASK: reg_rdata_o <= {14'h0000, mask};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // sequencer over the controller register file
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      op <= `BMD_OP_PACK;
      w32 <= 1'b0;
      sin <= 1'b0;
      n <= 9'h000;
      k <= 9'h000;
      src <= 16'h0000;
      dst <= 16'h0000;
      hold <= 16'h0000;
      acc <= 32'h00000000;
      res <= 32'h00000000;
      en_q <= 1'b0;
      evt_done <= 1'b0;
      evt_cerr <= 1'b0;
      busy_o <= 1'b0;
      shift_out_bit_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 16'h0000;
      mem_we_o <= 1'b0;
      mem_re_o <= 1'b0;
    end else begin
      en_q <= en_i;
      evt_done <= 1'b0;
      evt_cerr <= 1'b0;
      mem_we_o <= 1'b0;
      mem_re_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            if (!cnt_ok) begin
              evt_cerr <= 1'b1;
            end else begin
              op <= ctrl_op;
              w32 <= ctrl_w32;
              sin <= ctrl[`BMD_CTRL_SIN];
              n <= count[8:0];
              k <= 9'h000;
              src <= src_base;
              dst <= dst_base;
              acc <= 32'h00000000;
              busy_o <= 1'b1;
              state <= ST_RD;
              mem_re_o <= 1'b1;
              if (ctrl_op == `BMD_OP_SHL || ctrl_op == `BMD_OP_SHR ||
                  ctrl_op == `BMD_OP_ROL || ctrl_op == `BMD_OP_ROR) begin
                mem_addr_o <= dst_base;
              end else begin
                mem_addr_o <= src_base;
              end
            end
          end
        end
        ST_RD: begin
          state <= ST_RWAIT;
        end
        ST_RWAIT: begin
          case (op)
            `BMD_OP_PACK: begin
              if (!k[0]) begin
                hold <= {8'h00, mem_rdata_i[7:0]};
                if (last_k) begin
                  mem_wdata_o <= {mem_rdata_i[7:0], 8'h00};
                  mem_addr_o <= step_addr(dst, k >> 1);
                  mem_we_o <= 1'b1;
                  state <= ST_WR;
                end else begin
                  k <= k + 9'h001;
                  mem_addr_o <= step_addr(src, k + 9'h001);
                  mem_re_o <= 1'b1;
                  state <= ST_RD;
                end
              end else begin
                mem_wdata_o <= {hold[7:0], mem_rdata_i[7:0]};
                mem_addr_o <= step_addr(dst, k >> 1);
                mem_we_o <= 1'b1;
                state <= ST_WR;
              end
            end
            `BMD_OP_UNPACK: begin
              hold <= mem_rdata_i;
              mem_wdata_o <= {8'h00, mem_rdata_i[15:8]};
              mem_addr_o <= step_addr(dst, k);
              mem_we_o <= 1'b1;
              state <= ST_WR;
            end
            default: begin
              if (k == 9'h000) begin
                acc[15:0] <= mem_rdata_i;
              end else begin
                acc[31:16] <= mem_rdata_i;
              end
              if (word_last) begin
                state <= ST_CALC;
              end else begin
                k <= k + 9'h001;
                mem_addr_o <= step_addr(is_shift ? dst : src, 9'h001);
                mem_re_o <= 1'b1;
                state <= ST_RD;
              end
            end
          endcase
        end
        ST_CALC: begin
          res <= sh_res;
          if (is_shift) begin
            shift_out_bit_o <= sh_sout;
          end
          k <= 9'h000;
          mem_addr_o <= dst;
          mem_wdata_o <= sh_res[15:0];
          mem_we_o <= 1'b1;
          state <= ST_WR;
        end
        ST_WR: begin
          if (op == `BMD_OP_PACK) begin
            if (last_k) begin
              busy_o <= 1'b0;
              evt_done <= 1'b1;
              state <= ST_IDLE;
            end else begin
              k <= k + 9'h001;
              mem_addr_o <= step_addr(src, k + 9'h001);
              mem_re_o <= 1'b1;
              state <= ST_RD;
            end
          end else if (op == `BMD_OP_UNPACK) begin
            if (last_k) begin
              busy_o <= 1'b0;
              evt_done <= 1'b1;
              state <= ST_IDLE;
            end else if (!k[0]) begin
              k <= k + 9'h001;
              mem_wdata_o <= {8'h00, hold[7:0]};
              mem_addr_o <= step_addr(dst, k + 9'h001);
              mem_we_o <= 1'b1;
            end else begin
              k <= k + 9'h001;
              mem_addr_o <= step_addr(src, (k + 9'h001) >> 1);
              mem_re_o <= 1'b1;
              state <= ST_RD;
            end
          end else begin
            if (word_last) begin
              busy_o <= 1'b0;
              evt_done <= 1'b1;
              state <= ST_IDLE;
            end else begin
              k <= k + 9'h001;
              mem_addr_o <= step_addr(dst, 9'h001);
              mem_wdata_o <= res[31:16];
              mem_we_o <= 1'b1;
            end
          end
        end
        default: begin
          busy_o <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== dv/bmd_top_sva.sv ====
// port assertions for the bit manipulation datapath
`timescale 1ns/1ps
`include "bmd_defs.vh"
module bmd_top_sva (
  input wire        mclk_i,      // clock
  input wire        reset_n_i,   // sync reset
  input wire        en_i,        // enable
  input wire [7:0]  reg_addr_i,  // reg address
  input wire [15:0] reg_wdata_i, // reg data
  input wire        reg_we_i,    // reg write
  input wire [15:0] mem_wdata_o, // file data
  input wire        mem_we_o,    // file write
  input wire        mem_re_o,    // file read
  input wire [15:0] mem_rdata_i, // file word
  input wire        busy_o       // busy
);
  reg  [5:0]  ctrl;
  reg  [15:0] cnt;
  reg  [15:0] last;
  reg         en_d;
  reg         re_d;
  wire [2:0]  op = ctrl[2:0];
  wire        w = ctrl[3];
  wire        wr = mem_we_o && !w;
  wire [15:0] lm = ~(16'hFFFF << cnt);
  wire [15:0] hm = 16'hFFFF >> cnt;
  wire [31:0] rl = {last, last} << cnt;
  wire [31:0] rr = {last, last} >> cnt;
  wire        st = ctrl[4] && en_i && !en_d && !busy_o;
  wire        ok = op == `BMD_OP_GRAY ||
                   (cnt != 16'h0000 && cnt <= (op < 3'h2 ?
                   `BMD_BYTE_MAX : w ? `BMD_BITS32 : `BMD_BITS16));

  // shadow of control and count, last word read
  always @(posedge mclk_i) begin
    en_d <= en_i;
    re_d <= mem_re_o;
    if (re_d)
      last <= mem_rdata_i;
    if (!reset_n_i) begin
      ctrl <= 6'h00;
      cnt <= 16'h0000;
    end else if (reg_we_i && reg_addr_i == `BMD_REG_CTRL)
      ctrl <= reg_wdata_i[5:0];
    else if (reg_we_i && reg_addr_i == `BMD_REG_COUNT)
      cnt <= reg_wdata_i;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  property p_start;
    st && ok |=> busy_o && mem_re_o;
  endproperty
  a_start: assert property (p_start) else $error("no read");
  property p_bad_byte;
    st && !ok && op < 3'h2 |=> (!mem_we_o && !mem_re_o) [*8];
  endproperty
  a_bad_byte: assert property (p_bad_byte) else $error("bad pack");
  property p_bad_shift;
    st && !ok |-> ##1 !mem_we_o [*8];
  endproperty
  a_bad_shift: assert property (p_bad_shift) else $error("bad n");
  property p_unpack;
    mem_we_o && op == `BMD_OP_UNPACK |-> mem_wdata_o[15:8] == 8'h00;
  endproperty
  a_unpack: assert property (p_unpack) else $error("high");
  property p_shl;
    wr && op == `BMD_OP_SHL |-> (mem_wdata_o & lm) == (ctrl[5] ? lm : 16'h0);
  endproperty
  a_shl: assert property (p_shl) else $error("shl fill");
  property p_shr;
    wr && op == `BMD_OP_SHR |->
      (mem_wdata_o | hm) == (ctrl[5] ? 16'hFFFF : hm);
  endproperty
  a_shr: assert property (p_shr) else $error("shr fill");
  property p_rol;
    wr && op == `BMD_OP_ROL |-> mem_wdata_o == rl[31:16];
  endproperty
  a_rol: assert property (p_rol) else $error("rol");
  property p_ror;
    wr && op == `BMD_OP_ROR |-> mem_wdata_o == rr[15:0];
  endproperty
  a_ror: assert property (p_ror) else $error("ror");
  property p_gray;
    wr && op == `BMD_OP_GRAY |-> mem_wdata_o == (last ^ (last >> 1));
  endproperty
  a_gray: assert property (p_gray) else $error("gray");

  c_pack: cover property (st && ok && op == `BMD_OP_PACK);
  c_bad: cover property (st && !ok);
  c_gray: cover property (wr && op == `BMD_OP_GRAY);
endmodule

bind bmd_top bmd_top_sva u_sva (
  .mclk_i, .reset_n_i, .en_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
  .mem_wdata_o, .mem_we_o, .mem_re_o, .mem_rdata_i, .busy_o
);

// ==== dv/test_bit_manipulation_datapath.sv ====
// self-checking bench for the bit manipulation datapath
`timescale 1ns/1ps
`include "bmd_defs.vh"
module test_bit_manipulation_datapath;
  reg         mclk_i = 0;
  reg         reset_n_i = 0;
  reg         en_i = 0;
  reg  [7:0]  reg_addr_i = 0;
  reg  [15:0] reg_wdata_i = 0;
  reg         reg_we_i = 0;
  reg         reg_re_i = 0;
  reg  [15:0] mem_rdata_i = 0;
  wire [15:0] reg_rdata_o, mem_addr_o, mem_wdata_o;
  wire        mem_we_o, mem_re_o, shift_out_bit_o, busy_o, irq_o;
  reg  [15:0] mem [0:1023];
  reg  [15:0] rv, g, n;
  reg  [31:0] x, e;
  reg  [32:0] r;
  reg         s, w;
  integer     i, t, k, m, n_fail = 0, cmp_count = 0, seed = 32'hb16ca3d7;

  always #2 mclk_i = ~mclk_i;

  bmd_top DUT (.mclk_i, .reset_n_i, .en_i, .reg_addr_i, .reg_wdata_i,
    .reg_we_i, .reg_re_i, .reg_rdata_o, .mem_addr_o, .mem_wdata_o,
    .mem_we_o, .mem_re_o, .mem_rdata_i, .shift_out_bit_o, .busy_o, .irq_o);

  // register file, one cycle read, scrambled when not read
  always @(posedge mclk_i) begin
    if (mem_we_o)
      mem[mem_addr_o[9:0]] <= mem_wdata_o;
    mem_rdata_i <= mem_re_o ? mem[mem_addr_o[9:0]] : $random(seed);
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge mclk_i);
      reg_we_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_we_i <= 1'b0;
    end
  endtask

  task rd(input [7:0] a);
    begin
      @(posedge mclk_i);
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_re_i <= 1'b0;
      @(negedge mclk_i);
      rv = reg_rdata_o;
    end
  endtask

  // set up, start with a three cycle enable, wait, read status
  task run(input [5:0] c, input [15:0] cnt);
    begin
      wr(`BMD_REG_STATUS, 16'h0003);
      wr(`BMD_REG_CTRL, {10'h000, c});
      wr(`BMD_REG_COUNT, cnt);
      wr(`BMD_REG_SRC, 16'h0100);
      wr(`BMD_REG_DST, 16'h0200);
      @(posedge mclk_i);
      en_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      en_i <= 1'b0;
      k = 0;
      while (busy_o !== 1'b0 && k < 2000) begin
        @(posedge mclk_i);
        k = k + 1;
      end
      chk(k < 2000, 1);
      repeat (3) @(posedge mclk_i);
      rd(`BMD_REG_STATUS);
    end
  endtask

  // expected shift or rotate, shift-out bit on top
  function [32:0] shf(input [2:0] op, input wd, input si, input [31:0] v,
                      input [5:0] c);
    reg [31:0] y;
    reg        o;
    integer    j;
    begin
      y = v;
      o = 1'b0;
      for (j = 0; j < c; j = j + 1) begin
        if (op == `BMD_OP_SHL || op == `BMD_OP_ROL) begin
          o = wd ? y[31] : y[15];
          y = {y[30:0], op == `BMD_OP_ROL ? o : si};
        end else begin
          o = y[0];
          y = y >> 1;
          y[wd ? 31 : 15] = op == `BMD_OP_ROR ? o : si;
        end
        if (!wd)
          y[31:16] = 16'h0000;
      end
      shf = {o, y};
    end
  endfunction

  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // watchdog well beyond the expected run
  initial begin
    #240000;
    n_fail = n_fail + 1;
    end_of_test;
  end

  initial begin
    for (i = 0; i < 1024; i = i + 1)
      mem[i] = $random(seed);
    repeat (10) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    // registers start cleared, unmapped place reads zero
    for (i = 0; i < 7; i = i + 1) begin
      rd(i[7:0]);
      chk(rv, 0);
    end
    $display("reset values done");
    // pack and unpack, odd and even counts up to the top
    for (t = 0; t < 8; t = t + 1) begin
      n = t < 2 ? 16'd1 : t < 4 ? 16'd2 : t < 6 ? 16'd7 : 16'd256;
      for (i = 0; i < 256; i = i + 1)
        mem[256 + i] = $random(seed);
      m = t[0] ? n : (n + 1) / 2;
      g = mem[512 + m];
      run({5'h08, t[0]}, n);
      chk(rv[1:0], 2'b01);
      chk(irq_o, 0);
      for (i = 0; i < n; i = i + 1) begin
        x = mem[512 + i / 2];
        e = mem[256 + i / 2];
        if (t[0])
          chk(mem[512 + i], {8'h00, i[0] ? e[7:0] : e[15:8]});
        else
          chk(i[0] ? x[7:0] : x[15:8], mem[256 + i] & 16'h00FF);
      end
      if (!t[0] && n[0])
        chk(mem[512 + n / 2] & 16'h00FF, 0);
      chk(mem[512 + m], g);
    end
    $display("bytes done");
    // refused byte counts write nothing and raise the count error
    wr(`BMD_REG_MASK, 16'h0002);
    for (t = 0; t < 4; t = t + 1) begin
      g = mem[512];
      run({5'h08, t[0]}, t[1] ? 16'h0101 : 16'h0000);
      chk(rv[1], 1);
      chk(mem[512], g);
      chk(irq_o, 1);
    end
    wr(`BMD_REG_STATUS, 16'h0002);
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 0);
    $display("bad counts done");
    // shifts and rotates, both widths, edge, random and bad counts
    for (t = 0; t < 52; t = t + 1) begin
      w = t[2];
      x = $random(seed);
      n = {11'h000, x[4:0] & {w, 4'hF}} + 16'h0001;
      if (t < 16)
        n = t < 8 ? (w ? 16'd32 : 16'd16) : 16'd1;
      else if (t >= 40)
        n = t < 44 ? 16'd0 : w ? 16'd33 : 16'd17;
      s = $random(seed);
      mem[512] = $random(seed);
      mem[513] = $random(seed);
      x = {mem[513], mem[512]};
      run({s, 1'b1, w, 3'h2 + t[1:0]}, n);
      r = shf(3'h2 + t[1:0], w, s, w ? x : {16'h0000, x[15:0]}, n[5:0]);
      e = w ? r[31:0] : {x[31:16], r[15:0]};
      if (t < 40) begin
        chk(rv[1:0], 2'b01);
        chk({mem[513], mem[512]}, e);
        chk(shift_out_bit_o, r[32]);
      end else begin
        chk(rv[1], 1);
        chk({mem[513], mem[512]}, x);
      end
    end
    $display("shifts done");
    // gray code, both widths, pulse and level start, done interrupt
    wr(`BMD_REG_MASK, 16'h0001);
    for (t = 0; t < 4; t = t + 1) begin
      w = t[0];
      x = $random(seed);
      mem[256] = x[15:0];
      mem[257] = x[31:16];
      g = mem[513];
      run({1'b0, t[1], w, `BMD_OP_GRAY}, 16'h0000);
      e = w ? x ^ (x >> 1) : {g, x[15:0] ^ (x[15:0] >> 1)};
      chk({mem[513], mem[512]}, e);
      chk(rv[1:0], 2'b01);
      chk(irq_o, 1);
    end
    wr(`BMD_REG_STATUS, 16'h0001);
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 0);
    $display("gray done");
    end_of_test;
  end
endmodule
